// >>> sdram_pkg.sv
package sdram_pkg;
  localparam int num_banks = 4;
  localparam int bank_bits = 2;
  localparam int row_bits = 12;
  localparam int col_max_bits = 10;
  localparam int auto_precharge_bit = 10;
  localparam int mode_bits = 14;
  localparam int len_lsb = 0;
  localparam int order_bit = 3;
  localparam logic [2:0] len_full_page = 3'h7;
  localparam logic [13:0] mode_reset = 14'h0000;
  localparam logic [11:0] refresh_row_reset = 12'h000;
  localparam int read_latency = 2;

  typedef enum logic [3:0] {
    cmd_deselect,
    cmd_nop,
    cmd_active,
    cmd_read,
    cmd_write,
    cmd_terminate,
    cmd_precharge,
    cmd_refresh,
    cmd_self_refresh,
    load_mode_cmd
  } cmd_type;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } cmd_pins_type;

  typedef struct packed {
    logic [bank_bits-1:0] bank;
    logic [row_bits-1:0] addr;
  } addr_pins_type;

  typedef struct packed {
    logic active;
    logic write;
    logic auto_pre;
    logic [bank_bits-1:0] bank;
    logic [col_max_bits-1:0] start;
    logic [col_max_bits-1:0] count;
  } burst_type;

  // beats in a burst; zero means full page
  function automatic int burst_beats(input logic [2:0] code);
    if (code == len_full_page) begin
      return 0;
    end
    return (code > 3'h3) ? 8 : (1 << code);
  endfunction
endpackage

// >>> cmd_decode.sv
`timescale 1ns/100ps
module cmd_decode (
  input wire logic cke_i,
  input wire logic cke_prev_i,
  input wire sdram_pkg::cmd_pins_type pins_i,
  output sdram_pkg::cmd_type cmd_o
);
  always_comb begin
    cmd_o = sdram_pkg::cmd_deselect;
    if (cke_prev_i && !pins_i.cs_n) begin
      case ({pins_i.ras_n, pins_i.cas_n, pins_i.we_n})
        3'h7: cmd_o = sdram_pkg::cmd_nop;
        3'h3: cmd_o = sdram_pkg::cmd_active;
        3'h2: cmd_o = sdram_pkg::cmd_precharge;
        3'h1: cmd_o = cke_i ? sdram_pkg::cmd_refresh : sdram_pkg::cmd_self_refresh;
        3'h0: cmd_o = sdram_pkg::load_mode_cmd;
        3'h5: cmd_o = sdram_pkg::cmd_read;
        3'h4: cmd_o = sdram_pkg::cmd_write;
        3'h6: cmd_o = sdram_pkg::cmd_terminate;
        default: cmd_o = sdram_pkg::cmd_nop;
      endcase
      // clock enable low suspends every command but self refresh entry
      if (!cke_i && cmd_o != sdram_pkg::cmd_self_refresh) begin
        cmd_o = sdram_pkg::cmd_deselect;
      end
    end
  end
endmodule

// >>> burst_col.sv
`timescale 1ns/100ps
module burst_col #(
  parameter int COL_BITS = 8
) (
  input wire logic [COL_BITS-1:0] start_i,
  input wire logic [COL_BITS-1:0] index_i,
  input wire logic [2:0] len_code_i,
  input wire logic interleave_i,
  output logic [COL_BITS-1:0] col_o
);
  logic [COL_BITS-1:0] wrap_mask;
  logic [COL_BITS-1:0] step;

  always_comb begin
    if (len_code_i == sdram_pkg::len_full_page) begin
      wrap_mask = '1;
      step = start_i + index_i;
    end else begin
      wrap_mask = COL_BITS'(sdram_pkg::burst_beats(len_code_i) - 1);
      step = interleave_i ? (start_i ^ index_i) : (start_i + index_i);
    end
    // burst wraps inside its aligned block of columns
    col_o = (start_i & ~wrap_mask) | (step & wrap_mask);
  end
endmodule

// >>> sdram_device.sv
// Contract
// - all command, address, mask and data inputs are sampled at the rising clock edge
// - four banks of 4096 rows; 1024, 512 or 256 columns by width
// - activate: bank inputs pick the bank, twelve address lines pick the row
// - read or write: low address lines give start column, bank inputs the bank
// - accesses run as bursts of programmed length and order from the start column
// - chip select high deselects; low decodes no-op, activate, precharge, refresh, mode load
// - levels HLH read, HLL write, HHL burst terminate; mask sampled with accesses
// - refresh code with clock enable high refreshes, low enters self refresh
// - address bit ten selects auto-precharge for that access only
// - auto-precharge closes the row at burst end, otherwise the row stays open
// - precharge with bit ten high closes all banks, else the selected bank
// - read mask high floats the lane two clocks later, low drives data
// - write mask high leaves that lane of memory unchanged, low stores it
// - burst terminate cuts short the most recent read or write burst
// - deselect and no-op start nothing; running operations continue
// - auto refresh takes its row from the internal counter, ignoring address
`timescale 1ns/100ps
module sdram_device #(
  parameter int DATA_W = 16,
  parameter int COL_BITS = 8,
  parameter int ROW_BITS = 12,
  localparam int LANES = (DATA_W > 8) ? DATA_W / 8 : 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cke_i,
  input wire sdram_pkg::cmd_pins_type cmd_pins_i,
  input wire sdram_pkg::addr_pins_type addr_pins_i,
  input wire logic [LANES-1:0] dqm_i,
  input wire logic [DATA_W-1:0] dq_i,
  output logic [DATA_W-1:0] dq_o,
  output logic [LANES-1:0] dq_oe_o,
  output logic [sdram_pkg::mode_bits-1:0] mode_o,
  output logic self_refresh_o,
  output logic [sdram_pkg::num_banks-1:0] bank_open_o,
  output logic [sdram_pkg::row_bits-1:0] refresh_row_o
);
  localparam int LANE_W = DATA_W / LANES;
  localparam int IDX_W = sdram_pkg::bank_bits + ROW_BITS + COL_BITS;
  localparam int DEPTH = 2 ** IDX_W;

  // column bits and width together span twelve bits in every variant
  if (COL_BITS + $clog2(DATA_W) != 12 || COL_BITS < 8 || COL_BITS > 10 ||
      ROW_BITS < 1 || ROW_BITS > sdram_pkg::row_bits) begin : bad_params
    $error("unsupported width, column or row parameters");
  end

  sdram_pkg::cmd_type cmd;
  logic cke_prev_reg;
  logic cke_prev_next;
  logic [sdram_pkg::mode_bits-1:0] mode_reg;
  logic [sdram_pkg::mode_bits-1:0] mode_next;
  logic [sdram_pkg::num_banks-1:0] open_reg;
  logic [sdram_pkg::num_banks-1:0] open_next;
  logic [sdram_pkg::num_banks-1:0][sdram_pkg::row_bits-1:0] row_reg;
  logic [sdram_pkg::num_banks-1:0][sdram_pkg::row_bits-1:0] row_next;
  sdram_pkg::burst_type burst_reg;
  sdram_pkg::burst_type burst_next;
  logic [sdram_pkg::row_bits-1:0] refresh_reg;
  logic [sdram_pkg::row_bits-1:0] refresh_next;
  logic self_reg;
  logic self_next;

  logic [sdram_pkg::bank_bits-1:0] cmd_bank;
  logic [sdram_pkg::row_bits-1:0] cmd_addr;
  logic is_access;
  logic stop_burst;
  logic beat_on;
  logic beat_rd;
  logic beat_wr;
  logic beat_ap;
  logic beat_last;
  logic [sdram_pkg::bank_bits-1:0] beat_bank;
  logic [COL_BITS-1:0] beat_start;
  logic [COL_BITS-1:0] beat_index;
  logic [COL_BITS-1:0] beat_col;
  logic [IDX_W-1:0] mem_idx;
  int beats;

  logic [DATA_W-1:0] mem [DEPTH];
  logic rd_v1_reg;
  logic rd_v1_next;
  logic [DATA_W-1:0] rd_data1_reg;
  logic [DATA_W-1:0] rd_data1_next;
  logic [LANES-1:0] dqm_d1_reg;
  logic [LANES-1:0] dqm_d1_next;
  logic [DATA_W-1:0] dq_reg;
  logic [DATA_W-1:0] dq_next;
  logic [LANES-1:0] oe_reg;
  logic [LANES-1:0] oe_next;

  assign cmd_bank = addr_pins_i.bank;
  assign cmd_addr = addr_pins_i.addr;

  cmd_decode decoder (
    .cke_i(cke_i),
    .cke_prev_i(cke_prev_reg),
    .pins_i(cmd_pins_i),
    .cmd_o(cmd)
  );

  burst_col #(
    .COL_BITS(COL_BITS)
  ) column_gen (
    .start_i(beat_start),
    .index_i(beat_index),
    .len_code_i(mode_reg[sdram_pkg::len_lsb +: 3]),
    .interleave_i(mode_reg[sdram_pkg::order_bit]),
    .col_o(beat_col)
  );

  // current beat: the command cycle itself or a running burst
  always_comb begin
    is_access = !self_reg && (cmd == sdram_pkg::cmd_read || cmd == sdram_pkg::cmd_write);
    beats = sdram_pkg::burst_beats(mode_reg[sdram_pkg::len_lsb +: 3]);
    beat_start = is_access ? cmd_addr[COL_BITS-1:0] : burst_reg.start[COL_BITS-1:0];
    beat_index = is_access ? '0 : burst_reg.count[COL_BITS-1:0];
    beat_bank = is_access ? cmd_bank : burst_reg.bank;
    beat_ap = is_access ? cmd_addr[sdram_pkg::auto_precharge_bit] : burst_reg.auto_pre;
    // terminate, or precharge of the burst bank, ends the burst with no beat in that cycle
    stop_burst = cmd == sdram_pkg::cmd_terminate || (cmd == sdram_pkg::cmd_precharge &&
      (cmd_addr[sdram_pkg::auto_precharge_bit] || cmd_bank == burst_reg.bank));
    beat_on = is_access || (burst_reg.active && cke_i && !self_reg && !stop_burst);
    beat_wr = beat_on && (is_access ? cmd == sdram_pkg::cmd_write : burst_reg.write);
    beat_rd = beat_on && !beat_wr;
    beat_last = beat_on && beats != 0 && int'(beat_index) + 1 == beats;
    mem_idx = {beat_bank, row_reg[beat_bank][ROW_BITS-1:0], beat_col};
  end

  always_comb begin
    cke_prev_next = cke_i;
    mode_next = mode_reg;
    open_next = open_reg;
    row_next = row_reg;
    burst_next = burst_reg;
    refresh_next = refresh_reg;
    self_next = self_reg;
    if (self_reg) begin
      if (cke_i) begin
        self_next = 1'b0;
      end
    end else begin
      case (cmd)
        sdram_pkg::cmd_active: begin
          open_next[cmd_bank] = 1'b1;
          row_next[cmd_bank] = cmd_addr;
        end
        sdram_pkg::cmd_read, sdram_pkg::cmd_write: begin
          burst_next.active = 1'b1;
          burst_next.write = (cmd == sdram_pkg::cmd_write);
          burst_next.auto_pre = cmd_addr[sdram_pkg::auto_precharge_bit];
          burst_next.bank = cmd_bank;
          burst_next.start = '0;
          burst_next.start[COL_BITS-1:0] = cmd_addr[COL_BITS-1:0];
          burst_next.count = sdram_pkg::col_max_bits'(1);
        end
        sdram_pkg::cmd_terminate: begin
          burst_next.active = 1'b0;
        end
        sdram_pkg::cmd_precharge: begin
          if (cmd_addr[sdram_pkg::auto_precharge_bit]) begin
            open_next = '0;
          end else begin
            open_next[cmd_bank] = 1'b0;
          end
          if (cmd_addr[sdram_pkg::auto_precharge_bit] || cmd_bank == burst_reg.bank) begin
            burst_next.active = 1'b0;
          end
        end
        sdram_pkg::cmd_refresh: begin
          refresh_next = refresh_reg + 12'h001;
        end
        sdram_pkg::cmd_self_refresh: begin
          self_next = 1'b1;
          burst_next.active = 1'b0;
        end
        sdram_pkg::load_mode_cmd: begin
          mode_next = {cmd_bank, cmd_addr};
        end
        default: begin
        end
      endcase
      if (beat_on && !is_access) begin
        burst_next.count = burst_reg.count + sdram_pkg::col_max_bits'(1);
      end
      if (beat_last) begin
        burst_next.active = 1'b0;
        if (beat_ap) begin
          open_next[beat_bank] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cke_prev_reg <= 1'b0;
      mode_reg <= sdram_pkg::mode_reset;
      open_reg <= '0;
      row_reg <= '0;
      burst_reg <= '0;
      refresh_reg <= sdram_pkg::refresh_row_reset;
      self_reg <= 1'b0;
    end else begin
      cke_prev_reg <= cke_prev_next;
      mode_reg <= mode_next;
      open_reg <= open_next;
      row_reg <= row_next;
      burst_reg <= burst_next;
      refresh_reg <= refresh_next;
      self_reg <= self_next;
    end
  end

  // write lanes are masked in the same cycle as their data
  always_ff @(posedge clk_i) begin
    if (beat_wr) begin
      for (int l = 0; l < LANES; l++) begin
        if (!dqm_i[l]) begin
          mem[mem_idx][l*LANE_W +: LANE_W] <= dq_i[l*LANE_W +: LANE_W];
        end
      end
    end
  end

  // two-stage read path; the mask follows the data by the same two clocks
  always_comb begin
    rd_v1_next = beat_rd;
    rd_data1_next = mem[mem_idx];
    dqm_d1_next = dqm_i;
    dq_next = rd_data1_reg;
    oe_next = {LANES{rd_v1_reg}} & ~dqm_d1_reg;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rd_v1_reg <= 1'b0;
      rd_data1_reg <= '0;
      dqm_d1_reg <= '0;
      dq_reg <= '0;
      oe_reg <= '0;
    end else begin
      rd_v1_reg <= rd_v1_next;
      rd_data1_reg <= rd_data1_next;
      dqm_d1_reg <= dqm_d1_next;
      dq_reg <= dq_next;
      oe_reg <= oe_next;
    end
  end

  assign dq_o = dq_reg;
  assign dq_oe_o = oe_reg;
  assign mode_o = mode_reg;
  assign self_refresh_o = self_reg;
  assign bank_open_o = open_reg;
  assign refresh_row_o = refresh_reg;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  logic [sdram_pkg::num_banks-1:0] bank_sel;
  assign bank_sel = sdram_pkg::num_banks'(1) << cmd_bank;

  sequence masked_read_s;
    beat_rd && dqm_i[0];
  endsequence
  sequence open_read_s;
    beat_rd && !dqm_i[0];
  endsequence

  mask_hiz_a:
    assert property (masked_read_s |-> ##2 !dq_oe_o[0]) else $error("masked lane driven");
  read_drive_a:
    assert property (open_read_s |-> ##2 dq_oe_o[0]) else $error("read lane not driven");
  activate_row_a:
    assert property (cmd == sdram_pkg::cmd_active && !self_reg |=>
      bank_open_o[$past(cmd_bank)] && row_reg[$past(cmd_bank)] == $past(cmd_addr))
      else $error("activate did not open row");
  precharge_all_a:
    assert property (cmd == sdram_pkg::cmd_precharge && !self_reg &&
      cmd_addr[sdram_pkg::auto_precharge_bit] |=> bank_open_o == '0)
      else $error("precharge all left a bank open");
  precharge_one_a:
    assert property (cmd == sdram_pkg::cmd_precharge && !self_reg && !beat_on &&
      !cmd_addr[sdram_pkg::auto_precharge_bit] |=>
      bank_open_o == ($past(bank_open_o) & ~$past(bank_sel)))
      else $error("single precharge wrong banks");
  refresh_count_a:
    assert property (cmd == sdram_pkg::cmd_refresh && !self_reg |=>
      refresh_row_o == $past(refresh_row_o) + 12'h001) else $error("refresh row not stepped");
  self_entry_a:
    assert property (cmd == sdram_pkg::cmd_self_refresh && !self_reg |=> self_refresh_o)
      else $error("self refresh not entered");
  idle_keeps_a:
    assert property ((cmd == sdram_pkg::cmd_nop || cmd == sdram_pkg::cmd_deselect) &&
      !self_reg && !beat_on |=> $stable(bank_open_o) && $stable(mode_o))
      else $error("no-op changed state");
  terminate_stop_a:
    assert property (cmd == sdram_pkg::cmd_terminate && !self_reg |=> !burst_reg.active)
      else $error("burst not terminated");
  autopre_close_a:
    assert property (beat_last && beat_ap && !self_reg |=> !bank_open_o[$past(beat_bank)])
      else $error("auto precharge left row open");
  mode_load_a:
    assert property (cmd == sdram_pkg::load_mode_cmd && !self_reg |=>
      mode_o == $past({cmd_bank, cmd_addr})) else $error("mode not loaded");
endmodule

// >>> sdram_ctrl_model.sv
`timescale 1ns/100ps
module sdram_ctrl_model (
  input wire logic clk_i,
  output logic cke_o,
  output sdram_pkg::cmd_pins_type cmd_o,
  output sdram_pkg::addr_pins_type addr_o,
  output logic [1:0] dqm_o,
  output logic [15:0] dq_o
);
  initial begin
    cke_o = 1'b1;
    cmd_o = 4'h7;
    addr_o = '0;
    dqm_o = 2'h0;
    dq_o = 16'h5a5a;
  end

  // launched just after an edge, held until the next one
  task automatic send(input logic [3:0] p, input logic [1:0] b, input logic [11:0] a,
      input logic [1:0] m = 2'h0, input logic [15:0] d = 16'h0000, input bit drive = 1'b0);
    @(posedge clk_i);
    cmd_o <= p;
    addr_o <= {b, a};
    dqm_o <= m;
    // released data lines toggle so stale data never looks valid
    dq_o <= drive ? d : ~dq_o;
  endtask

  task automatic set_cke(input logic v);
    cke_o <= v;
  endtask

  task automatic idle(input int n);
    // nop cycles keep stale address lines, which the device must ignore
    repeat (n) send(4'h7, addr_o.bank, addr_o.addr);
  endtask

  // mode load only with all banks idle, then the two-clock wait
  task automatic load_mode(input logic [13:0] op);
    send(4'h0, op[13:12], op[11:0]);
    idle(2);
  endtask
endmodule

// >>> sdram_device_tb.sv
`timescale 1ns/100ps
module sdram_device_tb;
  localparam logic [3:0] c_nop = 4'h7;
  localparam logic [3:0] c_act = 4'h3;
  localparam logic [3:0] c_rd = 4'h5;
  localparam logic [3:0] c_wr = 4'h4;
  localparam logic [3:0] c_bst = 4'h6;
  localparam logic [3:0] c_pre = 4'h2;
  localparam logic [3:0] c_ref = 4'h1;
  localparam logic [3:0] c_des = 4'hb;
  logic clk_i;
  logic rst_n_i;
  logic cke;
  sdram_pkg::cmd_pins_type cmd;
  sdram_pkg::addr_pins_type addr;
  logic [1:0] dqm;
  logic [15:0] dq_w;
  logic [15:0] dq_r;
  logic [1:0] oe;
  logic [13:0] mode;
  logic self_ref;
  logic [3:0] bank_open;
  logic [11:0] ref_row;
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;

  sdram_device #(.DATA_W(16), .COL_BITS(8), .ROW_BITS(4)) u_sdram_device (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .cke_i(cke),
    .cmd_pins_i(cmd),
    .addr_pins_i(addr),
    .dqm_i(dqm),
    .dq_i(dq_w),
    .dq_o(dq_r),
    .dq_oe_o(oe),
    .mode_o(mode),
    .self_refresh_o(self_ref),
    .bank_open_o(bank_open),
    .refresh_row_o(ref_row)
  );

  sdram_ctrl_model u_sdram_ctrl_model (
    .clk_i(clk_i),
    .cke_o(cke),
    .cmd_o(cmd),
    .addr_o(addr),
    .dqm_o(dqm),
    .dq_o(dq_w)
  );

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic issue(input logic [3:0] p, input logic [1:0] b, input logic [11:0] a);
    u_sdram_ctrl_model.send(p, b, a);
  endtask

  task automatic settle(input int n);
    u_sdram_ctrl_model.idle(n);
    #1;
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      conclude();
    end
  end

  initial begin
    rst_n_i = 1'b0;
    repeat (6) @(posedge clk_i);
    #1;
    chk({oe, bank_open, self_ref, 9'h000}, 16'h0000); // reset state
    chk({2'h0, mode}, 16'h0000);
    chk({4'h0, ref_row}, 16'h0000);
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    // power-up pair of refreshes
    u_sdram_ctrl_model.idle(2);
    issue(c_ref, 2'h0, 12'h000);
    issue(c_ref, 2'h0, 12'h000);
    settle(1);
    chk({4'h0, ref_row}, 16'h0002);
    // length 2, sequential; bank bits kept too
    u_sdram_ctrl_model.load_mode(14'h2001);
    #1;
    chk({2'h0, mode}, 16'h2001);
    issue(c_des, 2'h1, 12'h001);
    settle(1);
    chk({12'h000, bank_open}, 16'h0000);
    for (int b = 0; b < 4; b++) begin
      issue(c_act, b[1:0], 12'(b));
    end
    settle(1);
    chk({12'h000, bank_open}, 16'h000f);
    issue(c_pre, 2'h3, 12'h000);
    settle(1);
    chk({12'h000, bank_open}, 16'h0007);
    // second write masks lane 0 of its second beat
    u_sdram_ctrl_model.send(c_wr, 2'h1, 12'h004, 2'h0, 16'h1111, 1'b1);
    u_sdram_ctrl_model.send(c_nop, 2'h0, 12'h000, 2'h0, 16'h2222, 1'b1);
    u_sdram_ctrl_model.send(c_wr, 2'h1, 12'h004, 2'h0, 16'h3333, 1'b1);
    u_sdram_ctrl_model.send(c_nop, 2'h0, 12'h000, 2'h1, 16'h4444, 1'b1);
    // read back, lane 1 masked on the second beat
    u_sdram_ctrl_model.send(c_rd, 2'h1, 12'h004, 2'h0, 16'h0000, 1'b0);
    u_sdram_ctrl_model.send(c_nop, 2'h0, 12'h000, 2'h2, 16'h0000, 1'b0);
    settle(1);
    chk(dq_r, 16'h3333);
    chk({14'h0000, oe}, 16'h0003);
    settle(1);
    chk({14'h0000, oe}, 16'h0001);
    chk({8'h00, dq_r[7:0]}, 16'h0022);
    settle(1);
    chk({14'h0000, oe}, 16'h0000);
    issue(c_rd, 2'h0, 12'h400);
    settle(1);
    chk({12'h000, bank_open}, 16'h0007);
    settle(3);
    chk({12'h000, bank_open}, 16'h0006);
    issue(c_wr, 2'h1, 12'h006);
    settle(4);
    chk({12'h000, bank_open}, 16'h0006);
    issue(c_pre, 2'h1, 12'h400);
    settle(1);
    chk({12'h000, bank_open}, 16'h0000);
    // length 8, cut after two beats
    u_sdram_ctrl_model.load_mode(14'h0003);
    issue(c_act, 2'h2, 12'h001);
    issue(c_rd, 2'h2, 12'h008);
    settle(0);
    u_sdram_ctrl_model.idle(1);
    issue(c_bst, 2'h0, 12'h000);
    settle(0);
    chk({14'h0000, oe}, 16'h0003);
    settle(1);
    chk({14'h0000, oe}, 16'h0003);
    settle(1);
    chk({14'h0000, oe}, 16'h0000);
    issue(c_pre, 2'h0, 12'h400);
    // precharge time before refresh
    u_sdram_ctrl_model.idle(2);
    issue(c_ref, 2'h3, 12'hfff);
    settle(1);
    chk({4'h0, ref_row}, 16'h0003);
    issue(c_ref, 2'h0, 12'h000);
    u_sdram_ctrl_model.set_cke(1'b0);
    settle(1);
    chk({15'h0000, self_ref}, 16'h0001);
    issue(c_act, 2'h0, 12'h001);
    settle(1);
    chk({12'h000, bank_open}, 16'h0000);
    chk({4'h0, ref_row}, 16'h0003);
    issue(c_nop, 2'h0, 12'h000);
    u_sdram_ctrl_model.set_cke(1'b1);
    settle(3);
    chk({15'h0000, self_ref}, 16'h0000);
    conclude();
  end
endmodule
